// >>> inc/pamx_regs.vh
/*
 Constants for the port A bits 1 to 3 pin function multiplexer: configuration
 field codes, field positions, remap bits and serial controller modes.
 Assumes it is included by bare name from the logic files.
*/
`ifndef PAMX_REGS_VH
`define PAMX_REGS_VH

// ----------------------------------------------------------------------
// Per-pin port configuration field codes
// ----------------------------------------------------------------------
`define PAMX_CFG_ANALOG 4'h0
`define PAMX_CFG_OUT 4'h1
`define PAMX_CFG_IN 4'h4
`define PAMX_CFG_OUT_OD 4'h5
`define PAMX_CFG_IN_PULL 4'h8
`define PAMX_CFG_ALT_OUT 4'h9
`define PAMX_CFG_ALT_OD 4'hd

// ----------------------------------------------------------------------
// Field positions in the low port A configuration word
// ----------------------------------------------------------------------
`define PAMX_FLD_BIT1 7:4
`define PAMX_FLD_BIT2 11:8
`define PAMX_FLD_BIT3 15:12

// ----------------------------------------------------------------------
// Timer 2 remap option bits
// ----------------------------------------------------------------------
`define PAMX_REMAP_CH2 5
`define PAMX_REMAP_CH3 6
`define PAMX_REMAP_CH4 7

// ----------------------------------------------------------------------
// Serial controller 2 function select and SPI configuration
// ----------------------------------------------------------------------
`define PAMX_SER_OFF 2'h0
`define PAMX_SER_UART 2'h1
`define PAMX_SER_SPI 2'h2
`define PAMX_SER_TWI 2'h3
`define PAMX_SPI_MASTER_BIT 4

// ----------------------------------------------------------------------
// Port pin positions and reset values
// ----------------------------------------------------------------------
`define PAMX_PIN_BIT1 1
`define PAMX_PIN_BIT2 2
`define PAMX_PIN_BIT3 3
`define PAMX_SYNC_RESET 1'h0
`define PAMX_SSEL_IDLE 1'h1

`endif

// >>> logic/pamx_pin_mux.v
/*
 Pin function multiplexer for port A bits 1 to 3: general purpose port,
 USB plus line analog path, timer 2 channels 2 to 4 and serial controller
 2 TWI and SPI signals; also the two flexible interrupt source selectors.
 Assumes all configuration inputs come from registers on clk, and that the
 pad ring resolves pin level from pin_out and pin_oe.
*/
// Summary of operation
// R1: Bit 1 analog field connects USB plus line
// R2: Timer channel 3 drives bit 1 when allowed
// R3: Bit 1 feeds timer channel 3 unremapped
// R4: TWI data open-drain on bit 1 when free
// R5: SPI slave data out on bit 1
// R6: SPI master samples bit 1 as input
// R7: Timer channel 4 drives bit 2 when allowed
// R8: Bit 2 feeds timer channel 4 unremapped
// R9: TWI clock open-drain on bit 2 when free
// R10: SPI master clock out on bit 2
// R11: SPI slave takes clock from bit 2
// R12: SPI slave takes select from bit 3
// R13: Timer channel 2 drives bit 3 when allowed
// R14: Bit 3 feeds timer channel 2 unremapped
// R15: Flexible interrupts sourced from any port pin
// R16: SPI config bit 4 set means master
// R17: No function selected gives plain port pin
`timescale 1ns/10ps
`default_nettype none
`include "pamx_regs.vh"

module pamx_pin_mux
#(
   parameter PIN_COUNT = 32,
   parameter SEL_WIDTH = 5,
   parameter HAS_USB = 1
)
(
   input wire clk,
   input wire rst_b,
   input wire [PIN_COUNT-1:0] gpio_pins_in,
   input wire [15:0] port_a_low_config_fields,
   input wire [3:1] port_a_data_out,
   input wire [7:0] timer2_remap_option,
   input wire [4:2] timer2_channel_output_enables,
   input wire [4:2] timer2_channel_out,
   input wire [1:0] serial2_function_select,
   input wire [7:0] serial2_spi_config,
   input wire serial2_twi_data_out,
   input wire serial2_twi_clock_out,
   input wire serial2_spi_slave_out_master_in_out,
   input wire serial2_spi_clock_out,
   input wire [SEL_WIDTH-1:0] flex_interrupt_c_source,
   input wire [SEL_WIDTH-1:0] flex_interrupt_d_source,
   output reg [3:1] pin_out,
   output reg [3:1] pin_oe,
   output reg usb_plus_line_connect,
   output reg [3:1] port_a_data_in,
   output reg [4:2] timer2_channel_in,
   output reg serial2_twi_data_in,
   output reg serial2_twi_clock_in,
   output reg serial2_spi_slave_out_master_in_in,
   output reg serial2_spi_clock_in,
   output reg serial2_spi_slave_select_n,
   output reg flex_interrupt_c,
   output reg flex_interrupt_d
);

   // ----------------------------------------------------------------------
   // Drive decode shared by all three pins
   // ----------------------------------------------------------------------
   // Returns {oe, out}; open-drain modes only ever pull low
   function [1:0] pamx_drive;
      input [3:0] field;
      input port_val;
      input alt_val;
      input alt_ok;
      begin
         case (field)
            `PAMX_CFG_OUT: pamx_drive = {1'b1, port_val};
            `PAMX_CFG_OUT_OD: pamx_drive = {~port_val, 1'b0};
            `PAMX_CFG_ALT_OUT: pamx_drive = {1'b1, alt_ok & alt_val};
            // Ineligible open-drain function releases the pad, never pulls it low
            `PAMX_CFG_ALT_OD: pamx_drive = {alt_ok & ~alt_val, 1'b0};
            default: pamx_drive = 2'h0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // Synchronised pin levels
   // ----------------------------------------------------------------------
   wire [PIN_COUNT-1:0] pins_sync;

   pamx_sync2 #(.WIDTH(PIN_COUNT)) u_sync
   (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(gpio_pins_in),
      .sync_out(pins_sync)
   );

   // ----------------------------------------------------------------------
   // Function qualifiers
   // ----------------------------------------------------------------------
   wire [3:0] field1 = port_a_low_config_fields[`PAMX_FLD_BIT1];
   wire [3:0] field2 = port_a_low_config_fields[`PAMX_FLD_BIT2];
   wire [3:0] field3 = port_a_low_config_fields[`PAMX_FLD_BIT3];
   wire remap3 = timer2_remap_option[`PAMX_REMAP_CH3];
   wire remap4 = timer2_remap_option[`PAMX_REMAP_CH4];
   wire remap2 = timer2_remap_option[`PAMX_REMAP_CH2];
   wire mode_twi = (serial2_function_select == `PAMX_SER_TWI);
   wire mode_spi = (serial2_function_select == `PAMX_SER_SPI);
   // Master polarity unconfirmed; kept to one bit so it is easy to flip
   wire spi_master = mode_spi & serial2_spi_config[`PAMX_SPI_MASTER_BIT]; // see R16
   wire spi_slave = mode_spi & ~serial2_spi_config[`PAMX_SPI_MASTER_BIT]; // see R16
   // Timer owns a pin only when unremapped and its output is enabled
   wire tim3_owns = ~remap3 & timer2_channel_output_enables[3]; // see R2
   wire tim4_owns = ~remap4 & timer2_channel_output_enables[4]; // see R7
   wire tim2_owns = ~remap2 & timer2_channel_output_enables[2]; // see R13
   wire usb_sel = (HAS_USB != 0) && (field1 == `PAMX_CFG_ANALOG); // see R1

   // ----------------------------------------------------------------------
   // Alternate function per pin
   // ----------------------------------------------------------------------
   reg alt1_val;
   reg alt1_ok;
   reg alt2_val;
   reg alt2_ok;
   reg alt3_val;
   reg alt3_ok;

   always @*
   begin
      alt1_val = 1'b0;
      alt1_ok = 1'b0;
      if (field1 == `PAMX_CFG_ALT_OD)
      begin
         alt1_ok = mode_twi & ~tim3_owns; // see R4
         alt1_val = serial2_twi_data_out; // see R4
      end
      else if (tim3_owns)
      begin
         alt1_ok = 1'b1; // see R2
         alt1_val = timer2_channel_out[3]; // see R2
      end
      else if (spi_slave)
      begin
         alt1_ok = 1'b1; // see R5
         alt1_val = serial2_spi_slave_out_master_in_out; // see R5
      end
   end

   always @*
   begin
      alt2_val = 1'b0;
      alt2_ok = 1'b0;
      if (field2 == `PAMX_CFG_ALT_OD)
      begin
         alt2_ok = mode_twi & ~tim4_owns; // see R9
         alt2_val = serial2_twi_clock_out; // see R9
      end
      else if (tim4_owns)
      begin
         alt2_ok = 1'b1; // see R7
         alt2_val = timer2_channel_out[4]; // see R7
      end
      else if (spi_master)
      begin
         alt2_ok = 1'b1; // see R10
         alt2_val = serial2_spi_clock_out; // see R10
      end
   end

   // Only the timer drives bit 3; slave select is an input
   always @*
   begin
      alt3_ok = tim2_owns & (field3 == `PAMX_CFG_ALT_OUT); // see R13
      alt3_val = timer2_channel_out[2]; // see R13
   end

   // ----------------------------------------------------------------------
   // Pad drive
   // ----------------------------------------------------------------------
   wire [1:0] drive1 = pamx_drive(field1, port_a_data_out[1], alt1_val, alt1_ok); // see R17
   wire [1:0] drive2 = pamx_drive(field2, port_a_data_out[2], alt2_val, alt2_ok); // see R17
   wire [1:0] drive3 = pamx_drive(field3, port_a_data_out[3], alt3_val, alt3_ok); // see R17

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_out <= 3'h0;
         pin_oe <= 3'h0;
         usb_plus_line_connect <= 1'b0;
      end
      else
      begin
         // Analog path takes the pad away from every digital driver
         pin_oe <= {drive3[1], drive2[1], drive1[1] & ~usb_sel}; // see R1
         pin_out <= {drive3[0], drive2[0], drive1[0]};
         usb_plus_line_connect <= usb_sel; // see R1
      end
   end

   // ----------------------------------------------------------------------
   // Peripheral inputs
   // ----------------------------------------------------------------------
   wire in1 = pins_sync[`PAMX_PIN_BIT1];
   wire in2 = pins_sync[`PAMX_PIN_BIT2];
   wire in3 = pins_sync[`PAMX_PIN_BIT3];

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         port_a_data_in <= 3'h0;
         timer2_channel_in <= 3'h0;
         serial2_twi_data_in <= `PAMX_SSEL_IDLE;
         serial2_twi_clock_in <= `PAMX_SSEL_IDLE;
         serial2_spi_slave_out_master_in_in <= 1'b0;
         serial2_spi_clock_in <= 1'b0;
         serial2_spi_slave_select_n <= `PAMX_SSEL_IDLE;
      end
      else
      begin
         port_a_data_in <= {in3, in2, in1}; // see R17
         // Remapped channels take their input from another pin
         timer2_channel_in[3] <= ~remap3 & in1; // see R3
         timer2_channel_in[4] <= ~remap4 & in2; // see R8
         timer2_channel_in[2] <= ~remap2 & in3; // see R14
         serial2_twi_data_in <= mode_twi ? in1 : `PAMX_SSEL_IDLE; // see R4
         serial2_twi_clock_in <= mode_twi ? in2 : `PAMX_SSEL_IDLE; // see R9
         serial2_spi_slave_out_master_in_in <= spi_master & in1; // see R6
         serial2_spi_clock_in <= spi_slave & in2; // see R11
         // Idle high outside slave mode so the controller never sees a select
         serial2_spi_slave_select_n <= spi_slave ? in3 : `PAMX_SSEL_IDLE; // see R12
      end
   end

   // ----------------------------------------------------------------------
   // Flexible interrupt sources
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flex_interrupt_c <= 1'b0;
         flex_interrupt_d <= 1'b0;
      end
      else
      begin
         flex_interrupt_c <= pins_sync[flex_interrupt_c_source]; // see R15
         flex_interrupt_d <= pins_sync[flex_interrupt_d_source]; // see R15
      end
   end

endmodule // pamx_pin_mux

`default_nettype wire

// >>> logic/pamx_sync2.v
/*
 Two-stage synchroniser for a bus of independent level inputs.
 Assumes each bit is a slow level from a pin; bits are not coherent.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pamx_regs.vh"

module pamx_sync2
#(
   parameter WIDTH = 32
)
(
   input wire clk,
   input wire rst_b,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   // First stage feeds only the second one
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1 <= {WIDTH{`PAMX_SYNC_RESET}};
         sync_out <= {WIDTH{`PAMX_SYNC_RESET}};
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // pamx_sync2

`default_nettype wire

// >>> verif/pamx_periph_model.sv
/* Stand-in for the timer 2 and serial controller 2 output side.
   Assumes the mux samples these outputs on the rising edge of clk. */
`timescale 1ns/10ps
`default_nettype none
module pamx_periph_model
#(
   parameter HOLD = 1
)
(
   input wire logic clk,
   input wire logic rst_b,
   output logic [4:2] tim_out,
   output logic twi_data_out,
   output logic twi_clock_out,
   output logic miso_out,
   output logic sclk_out
);
   logic [15:0] lfsr;
   integer cnt;
   // HOLD above 1 mimics a slow prescaled peer
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         lfsr <= 16'h0001;
         cnt <= 0;
      end
      else if (cnt + 1 >= HOLD)
      begin
         cnt <= 0;
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
      else
         cnt <= cnt + 1;
   assign {tim_out, twi_data_out, twi_clock_out, miso_out, sclk_out} = lfsr[6:0];
endmodule // pamx_periph_model
`default_nettype wire

// >>> verif/pamx_pin_mux_props.sv
/* Assertions on the port A pin mux ports.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
`include "pamx_regs.vh"
module pamx_props
#(
   parameter PIN_COUNT = 32
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [PIN_COUNT-1:0] gpio_pins_in,
   input wire logic [15:0] port_a_low_config_fields,
   input wire logic [7:0] timer2_remap_option,
   input wire logic [4:2] timer2_channel_output_enables,
   input wire logic [4:2] timer2_channel_out,
   input wire logic [1:0] serial2_function_select,
   input wire logic [7:0] serial2_spi_config,
   input wire logic serial2_twi_data_out,
   input wire logic serial2_spi_slave_out_master_in_out,
   input wire logic serial2_spi_clock_out,
   input wire logic [3:1] pin_out,
   input wire logic [3:1] pin_oe,
   input wire logic usb_plus_line_connect,
   input wire logic serial2_spi_clock_in,
   input wire logic serial2_spi_slave_select_n
);
   wire [3:0] f1 = port_a_low_config_fields[`PAMX_FLD_BIT1];
   wire [3:0] f2 = port_a_low_config_fields[`PAMX_FLD_BIT2];
   wire [3:0] f3 = port_a_low_config_fields[`PAMX_FLD_BIT3];
   wire [4:2] own = timer2_channel_output_enables & ~timer2_remap_option[7:5];
   wire spi = serial2_function_select == `PAMX_SER_SPI;
   wire mst = serial2_spi_config[`PAMX_SPI_MASTER_BIT];
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Slave mode held long enough for the two-flop input path
   sequence slave_s;
      (spi && !mst)[*4];
   endsequence
   usb_connect_a: assert property (f1 == `PAMX_CFG_ANALOG |=> usb_plus_line_connect)
      else $error("usb path not connected");
   ch3_drive_a: assert property (own[3] && f1 == `PAMX_CFG_ALT_OUT |=> pin_oe[1] && pin_out[1] == $past(timer2_channel_out[3]))
      else $error("channel 3 not on bit 1");
   twi_data_a: assert property (!own[3] && f1 == `PAMX_CFG_ALT_OD && serial2_function_select == `PAMX_SER_TWI
      |=> !pin_out[1] && pin_oe[1] == !$past(serial2_twi_data_out))
      else $error("twi data not open drain");
   od_release_a: assert property (own[3] && f1 == `PAMX_CFG_ALT_OD |=> !pin_oe[1])
      else $error("blocked open drain still pulls bit 1");
   slave_data_a: assert property (!own[3] && f1 == `PAMX_CFG_ALT_OUT && spi && !mst
      |=> pin_oe[1] && pin_out[1] == $past(serial2_spi_slave_out_master_in_out))
      else $error("slave data not on bit 1");
   ch4_drive_a: assert property (own[4] && f2 == `PAMX_CFG_ALT_OUT |=> pin_oe[2] && pin_out[2] == $past(timer2_channel_out[4]))
      else $error("channel 4 not on bit 2");
   spi_clock_a: assert property (!own[4] && f2 == `PAMX_CFG_ALT_OUT && spi && mst
      |=> pin_oe[2] && pin_out[2] == $past(serial2_spi_clock_out))
      else $error("master clock not on bit 2");
   ch2_drive_a: assert property (own[2] && f3 == `PAMX_CFG_ALT_OUT |=> pin_oe[3] && pin_out[3] == $past(timer2_channel_out[2]))
      else $error("channel 2 not on bit 3");
   slave_clock_a: assert property (slave_s |=> serial2_spi_clock_in == $past(gpio_pins_in[2], 3))
      else $error("slave clock input wrong");
   slave_select_a: assert property (slave_s |=> serial2_spi_slave_select_n == $past(gpio_pins_in[3], 3))
      else $error("slave select input wrong");
endmodule // pamx_props
bind pamx_pin_mux pamx_props #(.PIN_COUNT(PIN_COUNT)) u_props
(
   .clk(clk),
   .rst_b(rst_b),
   .gpio_pins_in(gpio_pins_in),
   .port_a_low_config_fields(port_a_low_config_fields),
   .timer2_remap_option(timer2_remap_option),
   .timer2_channel_output_enables(timer2_channel_output_enables),
   .timer2_channel_out(timer2_channel_out),
   .serial2_function_select(serial2_function_select),
   .serial2_spi_config(serial2_spi_config),
   .serial2_twi_data_out(serial2_twi_data_out),
   .serial2_spi_slave_out_master_in_out(serial2_spi_slave_out_master_in_out),
   .serial2_spi_clock_out(serial2_spi_clock_out),
   .pin_out(pin_out),
   .pin_oe(pin_oe),
   .usb_plus_line_connect(usb_plus_line_connect),
   .serial2_spi_clock_in(serial2_spi_clock_in),
   .serial2_spi_slave_select_n(serial2_spi_slave_select_n)
);
`default_nettype wire

// >>> verif/tb.sv
/* Random self-checking bench for the port A pin mux.
   Assumes registered outputs and a two-flop pad input path. */
`timescale 1ns/10ps
`default_nettype none
`include "pamx_regs.vh"
module tb;
   logic clk, rst_b;
   logic [31:0] ext, h0, h1, h2, seed;
   logic [15:0] cfg;
   logic [3:1] pdo;
   logic [7:0] remap, spicfg;
   logic [4:2] ten;
   logic [1:0] mode;
   logic [4:0] src_c, src_d;
   logic [6:0] prv;
   logic [3:0] codes [0:7];
   integer n_fail, n_tests, i;
   wire [4:2] tim, t_in;
   wire twi_d, twi_c, miso_o, sclk_o, usb, twi_di, twi_ci, miso_i, sclk_i, ssel_n, fc, fd;
   wire [3:1] p_out, p_oe, d_in;
   wire [3:1] pad = (p_oe & p_out) | (~p_oe & ext[3:1]);
   wire [31:0] gpio = {ext[31:4], pad, ext[0]};
   wire [4:2] own = ten & ~remap[7:5];
   wire spi = mode == `PAMX_SER_SPI;
   wire twi = mode == `PAMX_SER_TWI;
   wire mst = spicfg[`PAMX_SPI_MASTER_BIT];
   pamx_periph_model #(.HOLD(2)) peer_u (.clk(clk), .rst_b(rst_b), .tim_out(tim), .twi_data_out(twi_d),
      .twi_clock_out(twi_c), .miso_out(miso_o), .sclk_out(sclk_o));
   pamx_pin_mux dut_u (.clk(clk), .rst_b(rst_b), .gpio_pins_in(gpio), .port_a_low_config_fields(cfg),
      .port_a_data_out(pdo), .timer2_remap_option(remap), .timer2_channel_output_enables(ten),
      .timer2_channel_out(tim), .serial2_function_select(mode), .serial2_spi_config(spicfg),
      .serial2_twi_data_out(twi_d), .serial2_twi_clock_out(twi_c), .serial2_spi_slave_out_master_in_out(miso_o),
      .serial2_spi_clock_out(sclk_o), .flex_interrupt_c_source(src_c), .flex_interrupt_d_source(src_d),
      .pin_out(p_out), .pin_oe(p_oe), .usb_plus_line_connect(usb), .port_a_data_in(d_in),
      .timer2_channel_in(t_in), .serial2_twi_data_in(twi_di), .serial2_twi_clock_in(twi_ci),
      .serial2_spi_slave_out_master_in_in(miso_i), .serial2_spi_clock_in(sclk_i),
      .serial2_spi_slave_select_n(ssel_n), .flex_interrupt_c(fc), .flex_interrupt_d(fd));
   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   // Pad history mirrors the two sync flops plus the output register
   always @(posedge clk)
   begin
      h0 <= gpio;
      h1 <= h0;
      h2 <= h1;
      prv <= {tim, twi_d, twi_c, miso_o, sclk_o};
   end
   function automatic [1:0] exp_pin(input [3:0] f, input o, input t, input d, input ok, input v, input od, input w);
      case (f)
         `PAMX_CFG_OUT: exp_pin = {1'h1, d};
         `PAMX_CFG_OUT_OD: exp_pin = {~d, 1'h0};
         `PAMX_CFG_ALT_OUT: exp_pin = {1'h1, o ? t : ok & v};
         `PAMX_CFG_ALT_OD: exp_pin = {~o & od & ~w, 1'h0};
         default: exp_pin = 2'h0;
      endcase
   endfunction
   task cmp(input [15:0] got, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp)
         begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task check;
      logic [1:0] e1, e2, e3;
      logic [3:1] eo;
      logic [13:0] ei;
      begin
         e1 = exp_pin(cfg[7:4], own[3], prv[5], pdo[1], spi & ~mst, prv[1], twi, prv[3]);
         e2 = exp_pin(cfg[11:8], own[4], prv[6], pdo[2], spi & mst, prv[0], twi, prv[2]);
         e3 = exp_pin(cfg[15:12], own[2], prv[4], pdo[3], 1'h0, 1'h0, 1'h0, 1'h0);
         eo = {e3[1], e2[1], e1[1]};
         ei = {h2[3:1], h2[2] & ~remap[7], h2[1] & ~remap[6], h2[3] & ~remap[5], ~twi | h2[1], ~twi | h2[2],
            spi & mst & h2[1], spi & ~mst & h2[2], ~(spi & ~mst) | h2[3], h2[src_c], h2[src_d], cfg[7:4] == 4'h0};
         cmp({p_oe, p_out & eo}, {eo, eo & {e3[0], e2[0], e1[0]}});
         cmp({d_in, t_in, twi_di, twi_ci, miso_i, sclk_i, ssel_n, fc, fd, usb}, ei);
      end
   endtask
   task end_sim;
      begin
         $display("compares %0d mismatches %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial
   begin
      seed = 32'heae704e0;
      codes = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd, 4'h2};
      {n_fail, n_tests} = 0;
      {rst_b, ext, cfg, pdo, remap, spicfg, ten, mode, src_c, src_d} = 0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      cmp({p_oe, ssel_n, twi_di, usb}, 6'h06);
      $display("test reset done");
      rst_b = 1'h1;
      repeat (3) @(negedge clk);
      for (i = 0; i < 200; i = i + 1)
      begin
         {ext, pdo, spicfg, ten, mode, src_c, src_d} = {$random(seed), $random(seed)};
         remap = $random(seed);
         cfg = {codes[$unsigned($random(seed)) % 8], codes[$unsigned($random(seed)) % 8],
            codes[$unsigned($random(seed)) % 8], 4'($random(seed))};
         // Corner cases: every pin on an alternate code, timers racing the serial unit
         if (i < 16)
         begin
            cfg[15:4] = {i[0] ? 4'h9 : 4'hd, i[1] ? 4'hd : 4'h9, i[0] ? 4'h9 : 4'hd};
            remap[7:5] = i[3:1];
            mode = i[2] ? `PAMX_SER_SPI : `PAMX_SER_TWI;
         end
         repeat (5)
         begin
            @(negedge clk);
            check();
         end
      end
      $display("test random done");
      end_sim();
   end
endmodule // tb
`default_nettype wire
